// ### hdl/can_mailbox_status_irq.sv
// Purpose: transmit mailbox status, receive queue status and interrupt enables over APB
// Assumes: one clock, transmit engine and receive store on the same clock
// Notes: interrupt lines are levels
//        abort answers come back from the engine; a release to the store finishes here in one cycle
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "can_status_cfg.svh"
module can_mailbox_status_irq
    import can_status_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // transmit engine
    input wire tx_result_s [2:0] tx_result_i,
    input wire mbox_idx_t tx_lowest_prio_i,
    output logic [2:0] tx_pending_o,
    output logic [2:0] tx_abort_o,
    // receive store and master status
    input wire logic [1:0] rx_store_i,
    input wire logic sleep_ack_set_i,
    input wire logic sleep_ack_clr_i,
    input wire logic wakeup_set_i,
    input wire err_status_s err_i,
    output logic [1:0] rx_release_o,
    // interrupts
    output logic irq_tx_o,
    output logic irq_rx0_o,
    output logic irq_rx1_o,
    output logic irq_status_o
);
    // transmit mailbox state, one bit per mailbox
    logic [2:0] pend_ff;
    logic [2:0] abort_ff;
    // completion and outcome of the last request
    logic [2:0] request_complete_flag_ff;
    logic [2:0] ok_ff;
    logic [2:0] arb_ff;
    logic [2:0] tx_error_flag_ff;

    // receive queue state, one entry per queue
    logic [1:0] cnt_ff [2];
    logic [1:0] full_ff;
    logic [1:0] ovr_ff;
    logic [1:0] rel_ff;

    // enables and events
    logic [31:0] ie_ff;
    logic sleep_ev_ff;
    logic wake_ev_ff;
    logic err_ev_ff;
    // last error states; only a rising state is a detection
    logic [2:0] bo_ep_ew_ff;

    // bus answer; read data from a flop costs one wait state
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    // interrupt levels
    logic irq_tx_ff;
    logic irq_rx0_ff;
    logic irq_rx1_ff;
    logic irq_status_ff;

    // apb decode; only the first access cycle is taken, so the cycle with
    // pready high repeats the request without writing twice
    wire setup_acc = psel_i && penable_i && !pready_ff;
    wire wr = setup_acc && pwrite_i;
    wire rd = setup_acc && !pwrite_i;

    // register select by byte address
    wire hit_tsr = (paddr_i == `OFS_TRANSMIT_STATUS);
    wire hit_rq0 = (paddr_i == `OFS_RX_QUEUE0_STATUS);
    wire hit_rq1 = (paddr_i == `OFS_RX_QUEUE1_STATUS);
    wire hit_ie = (paddr_i == `OFS_IRQ_ENABLE_MASK);
    wire hit_esr = (paddr_i == `OFS_ERROR_STATUS);
    wire hit_txr = (paddr_i == `OFS_TX_REQUEST);
    wire hit_any = hit_tsr | hit_rq0 | hit_rq1 | hit_ie | hit_esr | hit_txr;

    // mailbox field extraction from the transmit status word
    function automatic logic [2:0] mbox_bits(input logic [31:0] w, input int lsb);
        mbox_bits = {w[lsb + 2 * `TSR_MBOX_STRIDE], w[lsb + `TSR_MBOX_STRIDE], w[lsb]};
    endfunction

    // writes of one clear a completion or ask for an abort
    wire [2:0] wr_request_complete_flag = (wr && hit_tsr) ? mbox_bits(pwdata_i, `TSR_REQUEST_COMPLETE_FLAG_LSB) : 3'h0;
    wire [2:0] wr_abort = (wr && hit_tsr) ? mbox_bits(pwdata_i, `TSR_ABORT_LSB) : 3'h0;
    // transmit request is written through a dedicated word, one bit per mailbox
    // a request for a mailbox already pending is dropped
    wire [2:0] wr_transmit_request = (wr && hit_txr) ? pwdata_i[2:0] & ~pend_ff : 3'h0;

    // any outcome ends an attempt; outcomes for idle mailboxes are ignored
    logic [2:0] done_any;
    always_comb begin
        for (int m = 0; m < 3; m++) begin
            done_any[m] = tx_result_i[m].done_ok | tx_result_i[m].done_arb_lost |
                          tx_result_i[m].done_bus_err | tx_result_i[m].aborted;
        end
    end

    // new request or write-one clears the completion, and with it the outcome flags
    wire [2:0] request_complete_flag_clr = wr_request_complete_flag | wr_transmit_request;
    // any outcome frees a pending mailbox, an abort included
    wire [2:0] nxt_pend = (pend_ff | wr_transmit_request) & ~(done_any & pend_ff);
    // abort has no effect on an idle mailbox and drops once it empties
    wire [2:0] nxt_abort = (abort_ff | (wr_abort & pend_ff)) & nxt_pend;
    // completion event beats a clear in the same cycle
    wire [2:0] nxt_request_complete_flag = (request_complete_flag_ff & ~request_complete_flag_clr) | (done_any & pend_ff);


    // an abort answer leaves the outcome flags alone; a finished attempt
    // beats a clear in the same cycle
    logic [2:0] nxt_ok, nxt_arb, nxt_tx_error_flag;
    always_comb begin
        for (int m = 0; m < 3; m++) begin
            nxt_ok[m] = request_complete_flag_clr[m] ? 1'b0 : ok_ff[m];
            nxt_arb[m] = request_complete_flag_clr[m] ? 1'b0 : arb_ff[m];
            nxt_tx_error_flag[m] = request_complete_flag_clr[m] ? 1'b0 : tx_error_flag_ff[m];
            if (pend_ff[m] && done_any[m] && !tx_result_i[m].aborted) begin
                nxt_ok[m] = tx_result_i[m].done_ok;
                nxt_arb[m] = tx_result_i[m].done_arb_lost;
                nxt_tx_error_flag[m] = tx_result_i[m].done_bus_err;
            end
        end
    end

    // mailbox code and lowest priority flags
    // the engine's priority index is only trusted while mailboxes wait
    wire [2:0] empty = ~pend_ff;
    wire all_pend = &pend_ff;
    wire multi_pend = (pend_ff[0] & pend_ff[1]) | (pend_ff[0] & pend_ff[2]) |
                      (pend_ff[1] & pend_ff[2]);
    // next free mailbox is the lowest empty index
    wire mbox_idx_t free_idx = empty[0] ? 2'h0 : (empty[1] ? 2'h1 : 2'h2);
    wire mbox_idx_t code = all_pend ? tx_lowest_prio_i : free_idx;

    // with fewer than two waiting there is no order to report
    wire [2:0] low_sel = 3'h1 << tx_lowest_prio_i;
    wire [2:0] low = multi_pend ? (pend_ff & low_sel) : 3'h0;

    // reserved bits read zero
    wire [31:0] tsr_word = {low, empty, code, abort_ff[2], 3'h0, tx_error_flag_ff[2], arb_ff[2],
                            ok_ff[2], request_complete_flag_ff[2], abort_ff[1], 3'h0, tx_error_flag_ff[1],
                            arb_ff[1], ok_ff[1], request_complete_flag_ff[1], abort_ff[0], 3'h0,
                            tx_error_flag_ff[0], arb_ff[0], ok_ff[0], request_complete_flag_ff[0]};

    // a queue holds at least one message
    function automatic logic has_msg(input logic [1:0] c);
        has_msg = (c != 2'h0);
    endfunction

    // receive queue updates
    // count, full and overrun of both queues, worked out side by side
    wire [1:0] hit_rq = {hit_rq1, hit_rq0};
    logic [1:0] nxt_cnt [2];
    logic [1:0] nxt_full, nxt_ovr, nxt_rel, rel_do, store_ok;
    always_comb begin
        for (int q = 0; q < 2; q++) begin
            // release only acts on a non-empty queue and finishes in one cycle
            rel_do[q] = rel_ff[q] && has_msg(cnt_ff[q]);
            nxt_rel[q] = wr && hit_rq[q] && pwdata_i[`RXQ_RELEASE_BIT] &&
                         has_msg(cnt_ff[q]);
            // a store in the cycle of a release takes the slot it frees
            store_ok[q] = rx_store_i[q] && ((cnt_ff[q] != `RXQ_DEPTH) || rel_do[q]);
            nxt_cnt[q] = cnt_ff[q] + {1'b0, store_ok[q]} - {1'b0, rel_do[q]};
            // software clears by writing one; a set below still wins
            nxt_full[q] = full_ff[q];
            nxt_ovr[q] = ovr_ff[q];
            if (wr && hit_rq[q] && pwdata_i[`RXQ_FULL_BIT]) begin
                nxt_full[q] = 1'b0;
            end
            if (wr && hit_rq[q] && pwdata_i[`RXQ_OVERRUN_BIT]) begin
                nxt_ovr[q] = 1'b0;
            end
            // full rises on the step into the last slot only
            if (nxt_cnt[q] == `RXQ_DEPTH && cnt_ff[q] != `RXQ_DEPTH) begin
                nxt_full[q] = 1'b1;
            end
            // a store that finds no slot is dropped
            if (rx_store_i[q] && cnt_ff[q] == `RXQ_DEPTH && !rel_do[q]) begin
                nxt_ovr[q] = 1'b1;
            end
        end
    end

    // queue word: release, overrun, full, a reserved zero, count
    function automatic logic [31:0] rxq_word(input logic [1:0] c, input logic f,
                                             input logic o, input logic r);
        rxq_word = {26'h0, r, o, f, 1'b0, c};
    endfunction

    // error states are levels; their rising edge counts as a detection
    wire [2:0] state_now = {err_i.bus_off_state, err_i.error_passive_state,
                            err_i.error_warning_state};
    wire [2:0] state_rise = state_now & ~bo_ep_ew_ff;

    // each source has its own enable
    wire lec_src = err_i.lec_hw_write && (err_i.last_error_code != 3'h0) && ie_ff[`IE_LEC];
    wire bus_off_state_src = state_rise[2] && ie_ff[`IE_BUSOFF];
    wire passive_src = state_rise[1] && ie_ff[`IE_PASSIVE];
    wire warning_src = state_rise[0] && ie_ff[`IE_WARN];
    wire err_src = lec_src | bus_off_state_src | passive_src | warning_src;

    // events clear on a written one; a new event in that cycle wins
    wire msr_clr = wr && hit_esr;
    wire clr_err_ev = msr_clr && pwdata_i[`ESR_ERR_EV_BIT];
    wire clr_wake_ev = msr_clr && pwdata_i[`ESR_WAKE_EV_BIT];
    wire clr_sleep_ev = msr_clr && pwdata_i[`ESR_SLEEP_EV_BIT];
    wire nxt_err_ev = err_src | (err_ev_ff & ~clr_err_ev);
    wire nxt_wake_ev = wakeup_set_i | (wake_ev_ff & ~clr_wake_ev);
    // a sleep acknowledge is only recorded while its enable is set
    wire nxt_sleep_ev = (sleep_ack_set_i & ie_ff[`IE_SLEEP]) |
                        (sleep_ev_ff & ~sleep_ack_clr_i & ~clr_sleep_ev);
    // event word shares the error status slot: events low, error state above
    // the error counters live in the fault confinement logic, not here
    wire [31:0] esr_word = {21'h0, err_i.last_error_code, state_now, sleep_ev_ff,
                            wake_ev_ff, err_ev_ff, 2'h0};

    // words built once so the read mux stays a plain selection
    wire [31:0] rq0_word = rxq_word(cnt_ff[0], full_ff[0], ovr_ff[0], rel_ff[0]);
    wire [31:0] rq1_word = rxq_word(cnt_ff[1], full_ff[1], ovr_ff[1], rel_ff[1]);
    wire [31:0] txr_word = {29'h0, pend_ff};

    // read mux; unmapped addresses read zero and flag an error
    wire [31:0] rd_mux = hit_tsr ? tsr_word :
                         hit_rq0 ? rq0_word :
                         hit_rq1 ? rq1_word :
                         hit_ie ? ie_ff :
                         hit_esr ? esr_word :
                         hit_txr ? txr_word : 32'h0;

    // interrupt levels, held while their sources stay true
    wire tx_done_src = ie_ff[`IE_TX_EMPTY] && (|request_complete_flag_ff);
    wire rx0_pend_src = ie_ff[`IE_PEND0] && has_msg(cnt_ff[0]);
    wire rx0_full_src = ie_ff[`IE_FULL0] && full_ff[0];
    wire rx0_ovr_src = ie_ff[`IE_OVR0] && ovr_ff[0];
    wire rx1_pend_src = ie_ff[`IE_PEND1] && has_msg(cnt_ff[1]);
    wire rx1_full_src = ie_ff[`IE_FULL1] && full_ff[1];
    wire rx1_ovr_src = ie_ff[`IE_OVR1] && ovr_ff[1];
    wire sleep_src = ie_ff[`IE_SLEEP] && sleep_ev_ff;
    wire wake_src = ie_ff[`IE_WAKEUP] && wake_ev_ff;
    wire err_irq_src = ie_ff[`IE_ERROR] && err_ev_ff;

    // levels, not pulses: a line stays up until software, or sleep_ack_clr_i for the sleep event, removes its source
    wire nxt_irq_tx = tx_done_src;
    wire nxt_irq_rx0 = rx0_pend_src || rx0_full_src || rx0_ovr_src;
    wire nxt_irq_rx1 = rx1_pend_src || rx1_full_src || rx1_ovr_src;
    wire nxt_irq_status = sleep_src || wake_src || err_irq_src;

    // transmit state
    // all flags start clear, so every mailbox reads empty
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            pend_ff <= 3'h0;
            abort_ff <= 3'h0;
            request_complete_flag_ff <= 3'h0;
            ok_ff <= 3'h0;
            arb_ff <= 3'h0;
            tx_error_flag_ff <= 3'h0;
        end else begin
            pend_ff <= nxt_pend;
            abort_ff <= nxt_abort;
            request_complete_flag_ff <= nxt_request_complete_flag;
            ok_ff <= nxt_ok;
            arb_ff <= nxt_arb;
            tx_error_flag_ff <= nxt_tx_error_flag;
        end
    end

    // receive queue state
    // a release pulse lasts one cycle; the count drops with it
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            cnt_ff <= '{2'h0, 2'h0};
            full_ff <= 2'h0;
            ovr_ff <= 2'h0;
            rel_ff <= 2'h0;
        end else begin
            cnt_ff <= nxt_cnt;
            full_ff <= nxt_full;
            ovr_ff <= nxt_ovr;
            rel_ff <= nxt_rel;
        end
    end

    // enables and events
    // only implemented enable bits are kept; the others read zero
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            ie_ff <= `IRQ_ENABLE_RESET;
            sleep_ev_ff <= 1'b0;
            wake_ev_ff <= 1'b0;
            err_ev_ff <= 1'b0;
            bo_ep_ew_ff <= 3'h0;
        end else begin
            if (wr && hit_ie) begin
                ie_ff <= pwdata_i & `IRQ_ENABLE_USED;
            end
            sleep_ev_ff <= nxt_sleep_ev;
            wake_ev_ff <= nxt_wake_ev;
            err_ev_ff <= nxt_err_ev;
            bo_ep_ew_ff <= state_now;
        end
    end

    // bus answer and registered outputs
    // each transfer is answered once, one cycle after it is taken
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            prdata_ff <= 32'h0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            irq_tx_ff <= 1'b0;
            irq_rx0_ff <= 1'b0;
            irq_rx1_ff <= 1'b0;
            irq_status_ff <= 1'b0;
        end else begin
            pready_ff <= setup_acc;
            pslverr_ff <= setup_acc && !hit_any;
            prdata_ff <= rd ? rd_mux : 32'h0;
            irq_tx_ff <= nxt_irq_tx;
            irq_rx0_ff <= nxt_irq_rx0;
            irq_rx1_ff <= nxt_irq_rx1;
            irq_status_ff <= nxt_irq_status;
        end
    end

    // bus answer
    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;

    // engine and store side
    assign tx_pending_o = pend_ff;
    assign tx_abort_o = abort_ff;
    assign rx_release_o = rel_ff;

    // interrupt lines
    assign irq_tx_o = irq_tx_ff;
    assign irq_rx0_o = irq_rx0_ff;
    assign irq_rx1_o = irq_rx1_ff;
    assign irq_status_o = irq_status_ff;
endmodule // can_mailbox_status_irq

// ### hdl/can_status_cfg.svh
// Purpose: register offsets, field positions and reset values of the status block
// Assumes: 32-bit APB data, byte addresses
// Notes: definitions only
`ifndef CAN_STATUS_CFG_SVH
`define CAN_STATUS_CFG_SVH
`define OFS_TRANSMIT_STATUS 12'h008
`define OFS_RX_QUEUE0_STATUS 12'h00C
`define OFS_RX_QUEUE1_STATUS 12'h010
`define OFS_IRQ_ENABLE_MASK 12'h014
`define OFS_ERROR_STATUS 12'h018
`define OFS_TX_REQUEST 12'h01C
`define IRQ_ENABLE_RESET 32'h0000_0000
`define IRQ_ENABLE_USED 32'h0003_8F7F
`define RXQ_RELEASE_BIT 5
`define RXQ_OVERRUN_BIT 4
`define RXQ_FULL_BIT 3
`define TSR_REQUEST_COMPLETE_FLAG_LSB 0
`define TSR_SUCCESS_LSB 1
`define TSR_ARBLOST_LSB 2
`define TSR_ERROR_LSB 3
`define TSR_ABORT_LSB 7
`define TSR_MBOX_STRIDE 8
`define TSR_EMPTY_LSB 26
`define TSR_CODE_LSB 24
`define TSR_LOW_LSB 29
`define RXQ_DEPTH 2'h3
`define IE_TX_EMPTY 0
`define IE_PEND0 1
`define IE_FULL0 2
`define IE_OVR0 3
`define IE_PEND1 4
`define IE_FULL1 5
`define IE_OVR1 6
`define IE_WARN 8
`define IE_PASSIVE 9
`define IE_BUSOFF 10
`define IE_LEC 11
`define IE_ERROR 15
`define IE_WAKEUP 16
`define IE_SLEEP 17
`define ESR_LEC_LSB 4
`define ESR_ERR_EV_BIT 2
`define ESR_WAKE_EV_BIT 3
`define ESR_SLEEP_EV_BIT 4
`endif

// ### hdl/can_status_pkg.sv
// Purpose: shared types of the status block
// Assumes: three transmit mailboxes, two receive queues
// Notes: offsets live in can_status_cfg.svh
package can_status_pkg;
    typedef logic [1:0] mbox_idx_t;
    // per-mailbox report from the transmit engine, one-cycle pulses
    typedef struct packed {
        logic done_ok;
        logic done_arb_lost;
        logic done_bus_err;
        logic aborted;
    } tx_result_s;
    // error status from the fault confinement logic
    typedef struct packed {
        logic [2:0] last_error_code;
        logic lec_hw_write;
        logic bus_off_state;
        logic error_passive_state;
        logic error_warning_state;
    } err_status_s;
    typedef enum logic [1:0] {
        RXQ_IDLE = 2'b00,
        RXQ_RELEASE = 2'b01
    } rxq_state_e;
endpackage

// ### verification/can_status_sva.sv
// Purpose: port checks of the mailbox status block
// Assumes: one clock domain, reset active low
// Notes: bound below its endmodule
`timescale 1ns/10ps
`include "can_status_cfg.svh"
module can_status_sva
    import can_status_pkg::*;
(
    // watched ports
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire tx_result_s [2:0] tx_result_i,
    input wire mbox_idx_t tx_lowest_prio_i,
    input wire logic [2:0] tx_pending_o,
    input wire logic [2:0] tx_abort_o
);
    logic [2:0] ab_hit, ok_hit;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    // engine answers only count for pending mailboxes
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            ab_hit[i] = tx_result_i[i].aborted & tx_pending_o[i];
            ok_hit[i] = tx_result_i[i].done_ok & tx_pending_o[i];
        end
    end
    // status read with a still pending set, so read data must agree with it
    sequence s_rd;
        pready_o && !pwrite_i && paddr_i == `OFS_TRANSMIT_STATUS
            && tx_pending_o == $past(tx_pending_o);
    endsequence
    sequence s_all;
        s_rd ##0 (&tx_pending_o);
    endsequence
    sequence s_ack;
        pready_o ##1 !pready_o;
    endsequence
    property p_ack; psel_i && penable_i && !pready_o |=> s_ack; endproperty
    property p_err; pslverr_o |-> pready_o && prdata_o == 32'h0; endproperty
    property p_one; s_rd ##0 ($countones(tx_pending_o) == 1) |-> prdata_o[31:29] == 3'h0;
    endproperty
    property p_empty; s_rd |-> prdata_o[28:26] == ~tx_pending_o; endproperty
    property p_code; s_all |-> prdata_o[25:24] == tx_lowest_prio_i; endproperty
    property p_low; s_all |-> prdata_o[31:29] == (3'h1 << tx_lowest_prio_i); endproperty
    property p_abort;
        |ab_hit |=> ((tx_pending_o | tx_abort_o) & $past(ab_hit)) == 3'h0;
    endproperty
    property p_ok; |ok_hit |=> (tx_pending_o & $past(ok_hit)) == 3'h0; endproperty
    a_ack: assert property (p_ack) else $error("answer not after one wait state");
    a_err: assert property (p_err) else $error("slave error without zero data");
    a_one: assert property (p_one) else $error("low flags set with one pending");
    a_empty: assert property (p_empty) else $error("empty flags wrong");
    a_code: assert property (p_code) else $error("code not lowest priority");
    a_low: assert property (p_low) else $error("low flags wrong");
    a_abort: assert property (p_abort) else $error("abort left mailbox pending");
    a_ok: assert property (p_ok) else $error("success left mailbox pending");
endmodule // can_status_sva
bind can_mailbox_status_irq can_status_sva chk (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .tx_result_i(tx_result_i), .tx_lowest_prio_i(tx_lowest_prio_i),
    .tx_pending_o(tx_pending_o), .tx_abort_o(tx_abort_o));

// ### verification/can_engine_model.sv
// Purpose: transmit engine stand-in on the far side
// Assumes: bench orders each result
// Notes: abort answer delay comes from the bench
`timescale 1ns/10ps
module can_engine_model
    import can_status_pkg::*;
(
    // bench commands
    input wire logic core_clk_i,
    input wire logic go_i,
    input wire logic [1:0] mb_i,
    input wire logic [1:0] kind_i,
    input wire logic [3:0] dly_i,
    // block side
    input wire logic [2:0] pending_i,
    input wire logic [2:0] abort_i,
    output tx_result_s [2:0] result_o,
    output mbox_idx_t lowest_o
);
    logic [3:0] wait_ff = 4'h0;
    logic [2:0] ab_req;
    // highest pending index is taken as lowest priority
    assign lowest_o = pending_i[2] ? 2'h2 : {1'b0, pending_i[1]};
    assign ab_req = abort_i & pending_i;
    // results only for pending mailboxes; aborts answered one at a time
    always_ff @(posedge core_clk_i) begin
        result_o <= '0;
        wait_ff <= (|ab_req) ? wait_ff + 4'h1 : 4'h0;
        if (go_i && pending_i[mb_i]) begin
            result_o[mb_i] <= tx_result_s'(4'h8 >> kind_i);
        end
        if (|ab_req && wait_ff >= dly_i) begin
            result_o[ab_req[0] ? 0 : (ab_req[1] ? 1 : 2)] <= tx_result_s'(4'h1);
            wait_ff <= 4'h0;
        end
    end
endmodule // can_engine_model

// ### verification/can_mailbox_status_irq_tb_top.sv
// Purpose: self-checking bench of the mailbox status block
// Assumes: 100 MHz clock
// Notes: engine stand-in answers transmit results
`timescale 1ns/10ps
`include "can_status_cfg.svh"
module can_mailbox_status_irq_tb_top
    import can_status_pkg::*;
;
    localparam logic [11:0] TSR = `OFS_TRANSMIT_STATUS;
    localparam logic [11:0] IER = `OFS_IRQ_ENABLE_MASK;
    localparam logic [11:0] ESR = `OFS_ERROR_STATUS;
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rdy, serr, slv;
    logic [11:0] addr = 12'h0;
    logic [31:0] wd = 32'h0, prd, rd;
    tx_result_s [2:0] res;
    mbox_idx_t low;
    logic [2:0] pend, abrt;
    logic [1:0] store = 2'h0, rel, mb = 2'h0, kind = 2'h0;
    logic [3:0] dly = 4'h0;
    logic go = 1'b0, slp = 1'b0, wk = 1'b0, i_tx, i_rx0, i_rx1, i_st;
    err_status_s err = '0;
    int error_cnt = 0, comparisons = 0;
    can_mailbox_status_irq uut (.core_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wd), .prdata_o(prd),
        .pready_o(rdy), .pslverr_o(serr), .tx_result_i(res), .tx_lowest_prio_i(low),
        .tx_pending_o(pend), .tx_abort_o(abrt), .rx_store_i(store), .sleep_ack_set_i(slp),
        .sleep_ack_clr_i(1'b0), .wakeup_set_i(wk), .err_i(err), .rx_release_o(rel),
        .irq_tx_o(i_tx), .irq_rx0_o(i_rx0), .irq_rx1_o(i_rx1), .irq_status_o(i_st));
    can_engine_model eng (.core_clk_i(clk), .go_i(go), .mb_i(mb), .kind_i(kind), .dly_i(dly),
        .pending_i(pend), .abort_i(abrt), .result_o(res), .lowest_o(low));
    always #5 clk = ~clk;
    function automatic logic [31:0] tsr_done(input int m, input int k);
        return 32'h1C00_0000 | ({28'h0, k == 2, k == 1, k == 0, 1'b1} << (8 * m));
    endfunction
    function automatic logic [31:0] rxq_exp(input int j);
        return {27'h0, j > 3, j >= 3, 1'b0, (j > 3) ? 2'h3 : 2'(j)};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer, held until ready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wd <= d;
        @(posedge clk);
        pen <= 1'b1;
        // only the watchdog ends a wait that never sees ready
        do begin
            @(posedge clk);
        end while (rdy !== 1'b1);
        rd = prd;
        slv = serr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic fire(input int m, input int k);
        mb <= 2'(m);
        kind <= 2'(k);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (int n = 0; n < 40 && pend !== 3'h0; n++) @(posedge clk);
    endtask
    task automatic finish_test();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        int m;
        void'($urandom(32'h8f508562));
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        rdc("tsr", TSR, 32'h1C00_0000);
        rdc("ier", IER, `IRQ_ENABLE_RESET);
        rdc("hole", 12'h020, 32'h0);
        chk("slverr", 32'h1, {31'h0, slv});
        m = $urandom;
        apb(1'b1, IER, m);
        rdc("ier_rw", IER, m & `IRQ_ENABLE_USED);
        apb(1'b1, IER, `IRQ_ENABLE_USED);
        // each outcome on a random mailbox, then an abort on the now idle mailbox, which must change nothing
        for (int i = 0; i < 6; i++) begin
            m = $urandom_range(2, 0);
            dly <= 4'($urandom_range(4, 0));
            apb(1'b1, `OFS_TX_REQUEST, 32'h1 << m);
            rdc("tsr_req", TSR, {3'h0, ~(3'h1 << m), (m == 0) ? 2'h1 : 2'h0, 24'h0});
            fire(m, i % 3);
            apb(1'b1, TSR, 32'h80 << (8 * m));
            fire(m, 3);
            rdc("tsr_done", TSR, tsr_done(m, i % 3));
            chk("irq_tx", 32'h1, {31'h0, i_tx});
            apb(1'b1, TSR, 32'h1 << (8 * m));
            rdc("tsr_clr", TSR, 32'h1C00_0000);
            chk("irq_tx_off", 32'h0, {31'h0, i_tx});
        end
        apb(1'b1, `OFS_TX_REQUEST, 32'h1);
        fire(0, 0);
        apb(1'b1, `OFS_TX_REQUEST, 32'h7);
        rdc("tsr_all", TSR, 32'h8200_0000);
        apb(1'b1, TSR, 32'h0080_8080);
        fire(0, 3);
        rdc("tsr_abort", TSR, 32'h1C01_0101);
        apb(1'b1, TSR, 32'h0001_0101);
        // fill each queue past full, then release until empty and once more
        for (int q = 0; q < 2; q++) begin
            for (int j = 1; j < 5; j++) begin
                store <= 2'(1 << q);
                @(posedge clk);
                store <= 2'h0;
                rdc("rxq_fill", 12'(`OFS_RX_QUEUE0_STATUS + 4 * q), rxq_exp(j));
                chk("irq_rx", 32'h1, {31'h0, q ? i_rx1 : i_rx0});
            end
            for (int j = 3; j >= 0; j--) begin
                apb(1'b1, 12'(`OFS_RX_QUEUE0_STATUS + 4 * q), 32'h38);
                chk("rx_rel", {31'h0, j > 0}, {31'h0, rel[q]});
                rdc("rxq_rel", 12'(`OFS_RX_QUEUE0_STATUS + 4 * q), rxq_exp(j > 0 ? j - 1 : 0));
            end
            chk("irq_rx_off", 32'h0, {31'h0, q ? i_rx1 : i_rx0});
        end
        // error source gated by its enable, then wake-up and sleep events
        apb(1'b1, IER, 32'h1 << `IE_ERROR);
        err.bus_off_state <= 1'b1;
        apb(1'b0, ESR, 32'h0);
        chk("err_gated", 32'h0, rd & 32'h4);
        err.bus_off_state <= 1'b0;
        apb(1'b1, IER, (32'h1 << `IE_ERROR) | (32'h1 << `IE_BUSOFF));
        err.bus_off_state <= 1'b1;
        apb(1'b0, ESR, 32'h0);
        chk("err_ev", 32'h4, rd & 32'h4);
        chk("irq_err", 32'h1, {31'h0, i_st});
        for (int e = 0; e < 2; e++) begin
            apb(1'b1, IER, 32'h1 << (e ? `IE_SLEEP : `IE_WAKEUP));
            apb(1'b1, ESR, 32'h1C);
            wk <= (e == 0);
            slp <= (e == 1);
            @(posedge clk);
            wk <= 1'b0;
            slp <= 1'b0;
            apb(1'b0, ESR, 32'h0);
            chk("event", 32'h8 << e, rd & 32'h1C);
            chk("irq_ev", 32'h1, {31'h0, i_st});
        end
        finish_test();
    end
    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        finish_test();
    end
endmodule // can_mailbox_status_irq_tb_top
